// ### hw/cht_pkg.sv
// constants and types for the core halt cross-trigger block
// assumes one 40 MHz clock domain; no software-visible registers
package cht_pkg;
  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // retire one more than this many further instructions after an external request
  localparam logic [3:0] STOP_SLACK_INSTR = 4'h3;
  // -----------------------------------------------------------------
  // cross-trigger actions
  // -----------------------------------------------------------------
  localparam int XT_ACTIONS = 8;
  localparam logic [2:0] XT_STOP = 3'h0;
  localparam logic [2:0] XT_RESUME = 3'h1;
  localparam logic [2:0] XT_ASSERT_HALT_OUT = 3'h2;
  // -----------------------------------------------------------------
  // debug modes
  // -----------------------------------------------------------------
  localparam logic DBG_BASIC = 1'b0;
  localparam logic DBG_EXTENDED = 1'b1;
  // -----------------------------------------------------------------
  // halt cause codes
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    CHT_CAUSE_NONE = 3'b000,
    CHT_CAUSE_BREAK = 3'b001,
    CHT_CAUSE_WATCH = 3'b010,
    CHT_CAUSE_HOST = 3'b011,
    CHT_CAUSE_EXT = 3'b100,
    CHT_CAUSE_XTRIG = 3'b101
  } cht_cause_t;
  // -----------------------------------------------------------------
  // run state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    CHT_RUN = 2'b00,
    CHT_DRAIN = 2'b01,
    CHT_HALTED = 2'b10
  } cht_state_t;
endpackage

// ### hw/cht_edge_det.sv
// rising-edge detector, one per cross-trigger action line
// assumes input already synchronous to clk_in
`timescale 1ns/1ps
module cht_edge_det
  import cht_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // level in, pulse out
  input wire logic level_in,
  output logic rise_out
);
  logic prev;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end
  assign rise_out = level_in & ~prev;
endmodule

// ### hw/cht_core_halt.sv
// halt cross-trigger logic of a soft processor core's debug interface
// assumes the pipeline reports retired instructions and obeys run_out;
// the debug bus delivers cross-trigger actions as levels on clk_in
`timescale 1ns/1ps
module cht_core_halt
  import cht_pkg::*;
#(
  parameter bit DISCRETE_PORTS = 1'b1,
  parameter bit DEBUG_MODE = DBG_EXTENDED
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // discrete cross-trigger pins
  input wire logic external_halt_request_in,
  output logic core_halted_flag_out,
  // host debugger commands and pipeline events
  input wire logic host_stop_in,
  input wire logic host_resume_in,
  input wire logic breakpoint_hit_in,
  input wire logic watchpoint_hit_in,
  input wire logic instr_retire_in,
  // debug bus cross-trigger actions
  input wire logic [XT_ACTIONS-1:0] xtrig_action_in,
  // core control and status
  output logic run_out,
  output logic [2:0] halt_cause_out,
  output logic xtrig_halt_out
);
  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // -----------------------------------------------------------------
  // request sampling and cross-trigger decode
  // -----------------------------------------------------------------
  logic ext_req;
  logic [XT_ACTIONS-1:0] xt_rise;
  wire ext_enabled = DISCRETE_PORTS;
  wire xt_enabled = (DEBUG_MODE == DBG_EXTENDED);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_req <= 1'b0;
    end else begin
      ext_req <= external_halt_request_in & ext_enabled;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < XT_ACTIONS; gi++) begin : g_xt
      cht_edge_det u_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .level_in(xtrig_action_in[gi] & xt_enabled),
        .rise_out(xt_rise[gi])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // cross-trigger action decode
  // -----------------------------------------------------------------
  // actions above the three mapped ones are accepted and have no effect
  wire xt_stop = xt_rise[XT_STOP];
  wire xt_resume = xt_rise[XT_RESUME];
  wire xt_halt_pulse = xt_rise[XT_ASSERT_HALT_OUT];

  // -----------------------------------------------------------------
  // halt state machine
  // -----------------------------------------------------------------
  cht_state_t state;
  cht_state_t next_state;
  cht_cause_t cause;
  cht_cause_t next_cause;
  logic [3:0] slack;
  logic [3:0] next_slack;

  // immediate stops take effect at once; external ones drain first
  wire stop_now = host_stop_in | breakpoint_hit_in | watchpoint_hit_in |
                  xt_stop;
  wire resume_cmd = host_resume_in | xt_resume;
  wire drain_done = instr_retire_in && (slack == 4'h0);

  // breakpoint outranks watchpoint, which outranks the host stop
  cht_cause_t now_cause;
  assign now_cause = breakpoint_hit_in ? CHT_CAUSE_BREAK :
                     watchpoint_hit_in ? CHT_CAUSE_WATCH :
                     host_stop_in ? CHT_CAUSE_HOST : CHT_CAUSE_XTRIG;

  always_comb begin
    next_state = state;
    next_cause = cause;
    next_slack = slack;
    unique case (state)
      CHT_RUN: begin
        if (stop_now) begin
          next_state = CHT_HALTED;
          next_cause = now_cause;
        end else if (ext_req) begin
          next_state = CHT_DRAIN;
          next_slack = STOP_SLACK_INSTR;
          next_cause = CHT_CAUSE_EXT;
        end
      end
      CHT_DRAIN: begin
        if (stop_now) begin
          next_state = CHT_HALTED;
          next_cause = now_cause;
        end else if (drain_done) begin
          next_state = CHT_HALTED;
        end else if (instr_retire_in) begin
          next_slack = slack - 4'h1;
        end
      end
      CHT_HALTED: begin
        // a held request does not re-halt until it has been seen low
        if (resume_cmd) begin
          next_state = CHT_RUN;
          next_cause = CHT_CAUSE_NONE;
        end
      end
      default: begin
        next_state = CHT_HALTED;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // re-arm of the external request
  // -----------------------------------------------------------------
  // a request still high after resume must drop before it halts again;
  // otherwise a peer's held level would stop the core again at once
  logic req_armed;
  wire next_armed = (state == CHT_HALTED) ? 1'b0 :
                    (req_armed | ~ext_req);
  wire drain_blocked = (next_state == CHT_DRAIN) && !req_armed;
  cht_state_t state_load;
  cht_cause_t cause_load;
  assign state_load = drain_blocked ? state : next_state;
  assign cause_load = drain_blocked ? cause : next_cause;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      req_armed <= 1'b1;
    end else begin
      req_armed <= next_armed;
    end
  end

  // -----------------------------------------------------------------
  // state, cause and drain counter
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= CHT_RUN;
    end else begin
      state <= state_load;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cause <= CHT_CAUSE_NONE;
    end else begin
      cause <= cause_load;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slack <= 4'h0;
    end else begin
      slack <= next_slack;
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  wire halted_now = (state == CHT_HALTED);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_halted_flag_out <= 1'b0;
      run_out <= 1'b0;
      xtrig_halt_out <= 1'b0;
    end else begin
      core_halted_flag_out <= halted_now & ext_enabled;
      run_out <= ~halted_now;
      xtrig_halt_out <= halted_now | xt_halt_pulse;
    end
  end

  // cause is registered like the flag; an external request sets it at drain entry, before the flag rises
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      halt_cause_out <= 3'h0;
    end else begin
      halt_cause_out <= cause;
    end
  end
endmodule

// ### verif/cht_core_halt_asserts.sv
// checker for the core halt cross-trigger block
// assumes retire pulses come every cycle while run_out is high
`timescale 1ns/1ps
module cht_core_halt_asserts (
  // design ports
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic external_halt_request_in,
  input wire logic core_halted_flag_out,
  input wire logic host_stop_in,
  input wire logic host_resume_in,
  input wire logic breakpoint_hit_in,
  input wire logic watchpoint_hit_in,
  input wire logic instr_retire_in,
  input wire logic [7:0] xtrig_action_in,
  input wire logic run_out,
  input wire logic [2:0] halt_cause_out,
  input wire logic xtrig_halt_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_stop;
    host_stop_in && run_out |-> ##2 core_halted_flag_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop late");
  property p_bkpt;
    breakpoint_hit_in && run_out |-> ##2 halt_cause_out == 3'h1;
  endproperty
  a_bkpt: assert property (p_bkpt) else $error("bkpt cause");
  property p_fall;
    $fell(core_halted_flag_out) |-> $past(host_resume_in, 2) ||
      ($past(xtrig_action_in[1], 2) && !$past(xtrig_action_in[1], 3));
  endproperty
  a_fall: assert property (p_fall) else $error("flag fell");
  property p_resume;
    host_resume_in && core_halted_flag_out |-> ##2 run_out;
  endproperty
  a_resume: assert property (p_resume) else $error("no run");
  property p_run;
    core_halted_flag_out |-> !run_out;
  endproperty
  a_run: assert property (p_run) else $error("run halted");
  property p_ext;
    $rose(external_halt_request_in) && run_out
      |-> ##[2:12] core_halted_flag_out && halt_cause_out == 3'h4;
  endproperty
  a_ext: assert property (p_ext) else $error("ext halt");
  property p_keep;
    core_halted_flag_out && $past(core_halted_flag_out)
      |-> $stable(halt_cause_out);
  endproperty
  a_keep: assert property (p_keep) else $error("cause moved");
  property p_xt;
    $rose(xtrig_action_in[0]) && run_out |-> ##[1:3] halt_cause_out == 3'h5;
  endproperty
  a_xt: assert property (p_xt) else $error("xtrig stop");
endmodule
bind cht_core_halt cht_core_halt_asserts cht_core_halt_asserts_i (.*);

// ### verif/cht_pipe_model.sv
// pipeline stand-in: retires one instruction each cycle it may run
// assumes run_out of the block drives run_in
`timescale 1ns/1ps
module cht_pipe_model (
  input wire logic clk_in,
  input wire logic run_in,
  output logic retire_out
);
  // a stopped core retires nothing
  always_ff @(negedge clk_in) begin
    retire_out <= run_in;
  end
endmodule

// ### verif/cht_core_halt_test.sv
// testbench for the core halt cross-trigger block
// assumes default parameters: discrete ports and extended mode
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module cht_core_halt_test;
  import cht_pkg::*;
  logic clk_in = 0, resetn_in = 0, ext = 0, flag, run, retire, xh;
  logic [3:0] pl = 0;
  logic [7:0] xt = 0;
  logic [2:0] cause;
  int failures = 0, n_compared = 0;
  always #12.5 clk_in = ~clk_in;
  cht_pipe_model cht_pipe_model_i (.clk_in(clk_in), .run_in(run),
    .retire_out(retire));
  cht_core_halt cht_core_halt_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .external_halt_request_in(ext), .core_halted_flag_out(flag),
    .host_stop_in(pl[0]), .host_resume_in(pl[1]),
    .breakpoint_hit_in(pl[2]), .watchpoint_hit_in(pl[3]),
    .instr_retire_in(retire), .xtrig_action_in(xt), .run_out(run),
    .halt_cause_out(cause), .xtrig_halt_out(xh));
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait for the halted flag to reach e
  task automatic wt(input logic e);
    int k;
    k = 0;
    while (flag !== e && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    `CHK("flag", e, flag)
    if (flag !== e) end_sim();
  endtask
  task automatic go(input logic [3:0] p);
    @(negedge clk_in);
    pl = p;
    @(negedge clk_in);
    pl = 0;
  endtask
  task automatic t_causes();
    logic [2:0] tc [3] = '{3'h3, 3'h1, 3'h2};
    for (int i = 0; i < 3; i++) begin
      go(4'h1 << (i == 0 ? 0 : i + 1));
      wt(1'b1);
      `CHK("cause", tc[i], cause)
      `CHK("halt trigger", 1'b1, xh)
      go(4'h1);
      repeat (3) @(negedge clk_in);
      `CHK("cause kept", tc[i], cause)
      go(4'h2);
      wt(1'b0);
      `CHK("run", 1'b1, run)
    end
  endtask
  task automatic t_ext();
    ext = 1;
    repeat (2) @(negedge clk_in);
    `CHK("slack", 1'b0, flag)
    wt(1'b1);
    `CHK("ext cause", 3'h4, cause)
    go(4'h2);
    wt(1'b0);
    repeat (10) @(negedge clk_in);
    `CHK("held", 1'b0, flag)
    ext = 0;
  endtask
  task automatic t_xt();
    logic seen;
    xt = 8'h01;
    wt(1'b1);
    `CHK("xt cause", 3'h5, cause)
    xt = 8'h02;
    wt(1'b0);
    seen = 0;
    xt = 8'hfc;
    repeat (3) begin
      @(negedge clk_in);
      seen |= xh;
    end
    `CHK("xt pulse", 1'b1, seen)
    `CHK("xt run", 1'b1, run)
    xt = 0;
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    `CHK("rst run", 1'b0, run)
    resetn_in = 1;
    repeat (6) @(negedge clk_in);
    t_causes();
    t_ext();
    t_xt();
    end_sim();
  end
endmodule
